// ===== src/sctr_regs.sv
// Register slice 0x24..0x2e: synthesizer calibration results and control,
// RC oscillator settings, and the test registers lost in sleep.
// Assumes the serial decoder presents one-cycle write strobes and a
// combinational address for reads, all synchronous to clk.
`timescale 1ns/10ps
`include "sctr_defines.svh"

// How it works
// - Coarse cap result: six bits, reset 0x20
// - Calibration control: seven bits, reset 0x0d
// - Two RC oscillator registers, resets 0x41, 0x00
// - Test registers 0x29-0x2e lost during sleep
// - Production test 0xbf enables sensor in idle
// - Wake forces test_b to 0x88 or 0x81
// - Wake forces test_a to 0x31 or 0x35
// - Base test bit 1 enables VCO selection
module sctr_regs
(
   input wire logic clk,
   input wire logic arst_n,
   input wire sctr_pkg::sctr_req_t req,
   input wire logic sleep_active,
   input wire logic wake_pulse,
   input wire logic radio_idle,
   input wire logic converter_keep_setting,
   output logic [7:0] rdata,
   output sctr_pkg::sctr_cfg_t cfg,
   output logic temp_sensor_enable,
   output logic vco_select_cal_enable
);

   logic [7:0] vco_cur_q;
   logic [7:0] coarse_q;
   logic [7:0] cal_ctrl_q;
   logic [7:0] rc_hi_q;
   logic [7:0] rc_lo_q;
   logic [7:0] syn_test_q;
   logic [7:0] prod_test_q;
   logic [7:0] gain_test_q;
   logic [7:0] test_b_q;
   logic [7:0] test_a_q;
   logic [7:0] test_base_q;
   logic [7:0] rdata_d;

   function automatic logic hit(input logic [5:0] ofs);
      hit = req.wr && (req.addr == ofs);
   endfunction

   // Retained calibration and oscillator registers
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         vco_cur_q <= `SCTR_RST_VCO_CUR;
         coarse_q <= `SCTR_RST_COARSE;
         cal_ctrl_q <= `SCTR_RST_CAL_CTRL;
         rc_hi_q <= `SCTR_RST_RC_HI;
         rc_lo_q <= `SCTR_RST_RC_LO;
      end
      else
      begin
         // Host writes of stored results replace a calibration run
         if (hit(`SCTR_OFS_VCO_CUR))
            vco_cur_q <= req.wdata & `SCTR_MASK_VCO_CUR;
         if (hit(`SCTR_OFS_COARSE))
            coarse_q <= req.wdata & `SCTR_MASK_COARSE;
         if (hit(`SCTR_OFS_CAL_CTRL))
            cal_ctrl_q <= req.wdata & `SCTR_MASK_7BIT;
         if (hit(`SCTR_OFS_RC_HI))
            rc_hi_q <= req.wdata & `SCTR_MASK_7BIT;
         if (hit(`SCTR_OFS_RC_LO))
            rc_lo_q <= req.wdata & `SCTR_MASK_7BIT;
      end
   end

   // Test group: contents lost while asleep, wake values forced
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         syn_test_q <= `SCTR_RST_SYN_TEST;
         prod_test_q <= `SCTR_RST_PROD_TEST;
         gain_test_q <= `SCTR_RST_GAIN_TEST;
         test_b_q <= `SCTR_RST_TEST_B;
         test_a_q <= `SCTR_RST_TEST_A;
         test_base_q <= `SCTR_RST_TEST_BASE;
      end
      else if (sleep_active)
      begin
         // Model loss of programming as return to power-on values
         syn_test_q <= `SCTR_RST_SYN_TEST;
         prod_test_q <= `SCTR_RST_PROD_TEST;
         gain_test_q <= `SCTR_RST_GAIN_TEST;
         test_b_q <= `SCTR_RST_TEST_B;
         test_a_q <= `SCTR_RST_TEST_A;
         test_base_q <= `SCTR_RST_TEST_BASE;
      end
      else if (wake_pulse)
      begin
         test_b_q <= converter_keep_setting ?
            `SCTR_WAKE_TEST_B_KEEP : `SCTR_RST_TEST_B;
         test_a_q <= converter_keep_setting ?
            `SCTR_WAKE_TEST_A_KEEP : `SCTR_RST_TEST_A;
      end
      else
      begin
         if (hit(`SCTR_OFS_SYN_TEST))
            syn_test_q <= req.wdata;
         if (hit(`SCTR_OFS_PROD_TEST))
            prod_test_q <= req.wdata;
         if (hit(`SCTR_OFS_GAIN_TEST))
            gain_test_q <= req.wdata;
         if (hit(`SCTR_OFS_TEST_B))
            test_b_q <= req.wdata;
         if (hit(`SCTR_OFS_TEST_A))
            test_a_q <= req.wdata;
         if (hit(`SCTR_OFS_TEST_BASE))
            test_base_q <= req.wdata;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb
   begin
      case (req.addr)
         `SCTR_OFS_VCO_CUR: rdata_d = vco_cur_q;
         `SCTR_OFS_COARSE: rdata_d = coarse_q;
         `SCTR_OFS_CAL_CTRL: rdata_d = cal_ctrl_q;
         `SCTR_OFS_RC_HI: rdata_d = rc_hi_q;
         `SCTR_OFS_RC_LO: rdata_d = rc_lo_q;
         `SCTR_OFS_SYN_TEST: rdata_d = syn_test_q;
         `SCTR_OFS_PROD_TEST: rdata_d = prod_test_q;
         `SCTR_OFS_GAIN_TEST: rdata_d = gain_test_q;
         `SCTR_OFS_TEST_B: rdata_d = test_b_q;
         `SCTR_OFS_TEST_A: rdata_d = test_a_q;
         `SCTR_OFS_TEST_BASE: rdata_d = test_base_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata <= 8'h00;
      else
         rdata <= rdata_d;
   end

   // Registered views handed to the analog side
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg <= '0;
         temp_sensor_enable <= 1'b0;
         vco_select_cal_enable <= 1'b0;
      end
      else
      begin
         cfg.vco_current <= {1'b0, vco_cur_q[4:0]};
         cfg.vco_high <= vco_cur_q[5];
         cfg.coarse_cap <= coarse_q[5:0];
         cfg.cal_ctrl <= cal_ctrl_q[6:0];
         cfg.rc_hi <= rc_hi_q[6:0];
         cfg.rc_lo <= rc_lo_q[6:0];
         cfg.syn_test <= syn_test_q;
         cfg.gain_test <= gain_test_q;
         cfg.test_b <= test_b_q;
         cfg.test_a <= test_a_q;
         cfg.test_base <= test_base_q;
         temp_sensor_enable <= radio_idle &&
            (prod_test_q == `SCTR_PROD_TEMP_ON);
         vco_select_cal_enable <= test_base_q[`SCTR_VCO_SEL_BIT];
      end
   end

endmodule

// ===== src/sctr_defines.svh
// Register offsets, field positions, reset and wake values for the
// synthesizer calibration, RC oscillator and test register slice.
// Assumes an 8-bit register access port from the serial interface decoder.
`ifndef SCTR_DEFINES_SVH
`define SCTR_DEFINES_SVH

`define SCTR_ADDR_W 6
`define SCTR_OFS_VCO_CUR 6'h24
`define SCTR_OFS_COARSE 6'h25
`define SCTR_OFS_CAL_CTRL 6'h26
`define SCTR_OFS_RC_HI 6'h27
`define SCTR_OFS_RC_LO 6'h28
`define SCTR_OFS_SYN_TEST 6'h29
`define SCTR_OFS_PROD_TEST 6'h2a
`define SCTR_OFS_GAIN_TEST 6'h2b
`define SCTR_OFS_TEST_B 6'h2c
`define SCTR_OFS_TEST_A 6'h2d
`define SCTR_OFS_TEST_BASE 6'h2e

`define SCTR_RST_VCO_CUR 8'h0a
`define SCTR_RST_COARSE 8'h20
`define SCTR_RST_CAL_CTRL 8'h0d
`define SCTR_RST_RC_HI 8'h41
`define SCTR_RST_RC_LO 8'h00
`define SCTR_RST_SYN_TEST 8'h59
`define SCTR_RST_PROD_TEST 8'h7f
`define SCTR_RST_GAIN_TEST 8'h3f
`define SCTR_RST_TEST_B 8'h88
`define SCTR_RST_TEST_A 8'h31
`define SCTR_RST_TEST_BASE 8'h0b

`define SCTR_MASK_VCO_CUR 8'h3f
`define SCTR_MASK_COARSE 8'h3f
`define SCTR_MASK_7BIT 8'h7f
`define SCTR_MASK_FULL 8'hff

`define SCTR_WAKE_TEST_B_KEEP 8'h81
`define SCTR_WAKE_TEST_A_KEEP 8'h35
`define SCTR_PROD_TEMP_ON 8'hbf
`define SCTR_VCO_SEL_BIT 1

`endif

// ===== src/sctr_pkg.sv
// Types for the synthesizer calibration and test register slice.
// Assumes sctr_defines.svh is on the include path.
package sctr_pkg;

   typedef struct packed
   {
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } sctr_req_t;

   typedef struct packed
   {
      logic [5:0] vco_current;
      logic vco_high;
      logic [5:0] coarse_cap;
      logic [6:0] cal_ctrl;
      logic [6:0] rc_hi;
      logic [6:0] rc_lo;
      logic [7:0] syn_test;
      logic [7:0] gain_test;
      logic [7:0] test_b;
      logic [7:0] test_a;
      logic [7:0] test_base;
   } sctr_cfg_t;

endpackage

// ===== test/sctr_regs_monitor.sv
// Port checker for the register slice.
// Assumes the one-cycle read latency and two-cycle write-to-cfg latency of the register port.
`timescale 1ns/10ps
module sctr_regs_monitor
(
   input wire logic clk,
   input wire logic arst_n,
   input wire sctr_pkg::sctr_req_t req,
   input wire logic sleep_active,
   input wire logic wake_pulse,
   input wire logic radio_idle,
   input wire logic converter_keep_setting,
   input wire logic [7:0] rdata,
   input wire sctr_pkg::sctr_cfg_t cfg,
   input wire logic temp_sensor_enable,
   input wire logic vco_select_cal_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_wr(logic [5:0] a);
      req.wr && req.addr == a;
   endsequence
   sequence s_wake;
      wake_pulse && !sleep_active ##1 !sleep_active;
   endsequence
   a_coarse_write: assert property (s_wr(6'h25) |=> ##1
      cfg.coarse_cap == $past(req.wdata[5:0], 2)) else $error("coarse");
   a_cal_ctrl_write: assert property (s_wr(6'h26) |=> ##1
      cfg.cal_ctrl == $past(req.wdata[6:0], 2)) else $error("cal ctrl");
   a_rc_hi_write: assert property (s_wr(6'h27) |=> ##1
      cfg.rc_hi == $past(req.wdata[6:0], 2)) else $error("rc hi");
   a_sleep_held: assert property (sleep_active [*3] |->
      cfg.test_a == 8'h31 && vco_select_cal_enable) else $error("sleep");
   a_wake_force_b: assert property (s_wake |=> cfg.test_b ==
      ($past(converter_keep_setting, 2) ? 8'h81 : 8'h88)) else $error("b");
   a_wake_force_a: assert property (s_wake |=> cfg.test_a ==
      ($past(converter_keep_setting, 2) ? 8'h35 : 8'h31)) else $error("a");
   a_temp_idle: assert property (!radio_idle |=> !temp_sensor_enable)
      else $error("temp");
   a_unmapped_zero: assert property (!(req.addr inside {[6'h24:6'h2e]})
      |=> rdata == 8'h00) else $error("unmapped");
   a_reserved_zero: assert property (req.addr inside {[6'h24:6'h28]}
      |=> !rdata[7]) else $error("reserved");
endmodule
bind sctr_regs sctr_regs_monitor u_sctr_regs_monitor (.clk(clk),
   .arst_n(arst_n), .req(req), .sleep_active(sleep_active),
   .wake_pulse(wake_pulse), .radio_idle(radio_idle),
   .converter_keep_setting(converter_keep_setting), .rdata(rdata),
   .cfg(cfg), .temp_sensor_enable(temp_sensor_enable),
   .vco_select_cal_enable(vco_select_cal_enable));

// ===== test/sctr_host.sv
// Host side of the register port: single-byte reads, and single-byte writes except to 0x29 and 0x2b.
// Assumes rdata answers the address one edge after it is presented.
`timescale 1ns/10ps
module sctr_host
(
   input wire logic clk,
   input wire logic [7:0] rdata,
   output sctr_pkg::sctr_req_t req
);
   initial req = '0;
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      if (a == 6'h29 || a == 6'h2b) return;
      @(posedge clk);
      req <= '{1'b1, a, d};
      @(posedge clk);
      req.wr <= 1'b0;
      req.wdata <= ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      req.addr <= a;
      repeat (2) @(posedge clk);
      #1 d = rdata;
   endtask
endmodule

// ===== test/sctr_regs_bench.sv
// Self-checking bench for the register slice.
// Assumes the host model drives the register port.
`timescale 1ns/10ps
module sctr_regs_bench;
   logic clk = 0, arst_n = 0, sleep_active = 0, wake_pulse = 0;
   logic radio_idle = 0, converter_keep_setting = 0, temp_sensor_enable;
   logic vco_select_cal_enable;
   logic [7:0] rdata;
   sctr_pkg::sctr_req_t req;
   sctr_pkg::sctr_cfg_t cfg;
   int mismatches = 0, n_compared = 0;
   logic [7:0] rst_tab [11] = '{8'h0a, 8'h20, 8'h0d, 8'h41, 8'h00, 8'h59,
      8'h7f, 8'h3f, 8'h88, 8'h31, 8'h0b};
   logic [7:0] msk [5] = '{8'h3f, 8'h3f, 8'h7f, 8'h7f, 8'h7f};
   always #5 clk = ~clk;
   sctr_host u_sctr_host (.clk(clk), .rdata(rdata), .req(req));
   sctr_regs u_sctr_regs (.clk(clk), .arst_n(arst_n), .req(req),
      .sleep_active(sleep_active), .wake_pulse(wake_pulse),
      .radio_idle(radio_idle), .converter_keep_setting(converter_keep_setting),
      .rdata(rdata), .cfg(cfg), .temp_sensor_enable(temp_sensor_enable),
      .vco_select_cal_enable(vco_select_cal_enable));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_sctr_host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      mismatches++;
      give_verdict;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 11; i++)
         rd_chk(6'(36 + i), rst_tab[i]);
      chk({7'h00, vco_select_cal_enable}, 8'h01);
      chk(cfg.syn_test, 8'h59);
      chk(cfg.gain_test, 8'h3f);
      chk(cfg.test_base, 8'h0b);
      chk({1'b0, cfg.rc_hi}, 8'h41);
      for (int i = 0; i < 5; i++) u_sctr_host.wr(6'(36 + i), 8'hff);
      for (int i = 0; i < 5; i++) rd_chk(6'(36 + i), msk[i]);
      chk({2'b00, cfg.vco_current}, 8'h1f);
      chk({7'h00, cfg.vco_high}, 8'h01);
      chk({1'b0, cfg.rc_lo}, 8'h7f);
      rd_chk(6'h30, 8'h00);
      u_sctr_host.wr(6'h2a, 8'hbf);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, temp_sensor_enable}, 8'h00);
      @(posedge clk) radio_idle <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({7'h00, temp_sensor_enable}, 8'h01);
      // Default restored while still idle, before leaving idle
      u_sctr_host.wr(6'h2a, 8'h7f);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, temp_sensor_enable}, 8'h00);
      @(posedge clk) radio_idle <= 1'b0;
      u_sctr_host.wr(6'h2e, 8'h00);
      repeat (3) @(posedge clk);
      #1 chk({7'h00, vco_select_cal_enable}, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk);
         sleep_active <= 1'b1;
         converter_keep_setting <= k[0];
         u_sctr_host.wr(6'h2d, 8'h00);
         rd_chk(6'h2e, 8'h0b);
         @(posedge clk) sleep_active <= 1'b0;
         @(posedge clk) wake_pulse <= 1'b1;
         @(posedge clk) wake_pulse <= 1'b0;
         rd_chk(6'h2c, k[0] ? 8'h81 : 8'h88);
         rd_chk(6'h2d, k[0] ? 8'h35 : 8'h31);
         rd_chk(6'h25, 8'h3f);
      end
      // Mid-run reset returns retained and test registers to defaults
      @(posedge clk) arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rd_chk(6'h25, 8'h20);
      rd_chk(6'h2c, 8'h88);
      // Stored per-channel results written back instead of a calibration
      u_sctr_host.wr(6'h24, 8'h2a);
      u_sctr_host.wr(6'h25, 8'h11);
      rd_chk(6'h24, 8'h2a);
      rd_chk(6'h25, 8'h11);
      chk({2'b00, cfg.vco_current}, 8'h0a);
      chk({7'h00, cfg.vco_high}, 8'h01);
      give_verdict;
   end
endmodule
